//--- rtl/quad_dac_frame_defines.svh
// Frame layout, register codes and span constants of the serial frame decoder
`ifndef QUAD_DAC_FRAME_DEFINES_SVH
`define QUAD_DAC_FRAME_DEFINES_SVH

`define FRAME_BITS      24
`define FRAME_CNT_W     5
`define FRAME_LAST_BIT  5'h17
`define FLD_RW          23
`define FLD_ZERO        22
`define FLD_SEL_HI      21
`define FLD_SEL_LO      19
`define FLD_ADDR_HI     18
`define FLD_ADDR_LO     16
`define FLD_DATA_HI     15
`define DATA_W          16
`define DAC_BITS_DEF    16

`define SEL_DAC         3'h0
`define SEL_RANGE       3'h1
`define SEL_POWER       3'h2
`define SEL_CTRL        3'h3

`define ADDR_ALL        3'h4
`define CTRL_ADDR_CFG   3'h1
`define POWER_W         11
`define CTRL_W          4

`define RANGE_U5        3'h0
`define RANGE_U10       3'h1
`define RANGE_U10P8     3'h2
`define RANGE_B5        3'h3
`define RANGE_B10       3'h4
`define RANGE_B10P8     3'h5

`define SPAN_X100_5     9'h0c8
`define SPAN_X100_10    9'h190
`define SPAN_X100_10P8  9'h1b0
`define SPAN_X100_NONE  9'h000

`define RESET_DATA      16'h0000
`define RESET_RANGE     3'h0

`endif

//--- rtl/quad_dac_frame_pkg.sv
// Shared types of the serial frame decoder
package quad_dac_frame_pkg;
  typedef logic [15:0] dac_word_t;
  typedef logic [2:0]  range_code_t;
  typedef logic [8:0]  span_x100_t;
  typedef logic [23:0] frame_t;
endpackage : quad_dac_frame_pkg

//--- rtl/quad_dac_serial_frame_decoder.sv
// Serial command frame decoder of a quad voltage-output converter
//
// Function
// - Frame is exactly 24 bits, decoded once full
// - Bits shift in most significant first
// - Split: flag, zero, select, address, data
// - Top bit picks read or write
// - Select codes: data, range, power, control
// - Select 000 writes addressed channel data
// - Address 0-3 one channel, 4 all
// - Data left aligned, unused low bits ignored
// - Every register readable and writable
// - Offset binary: midcode is zero output
// - Twos complement: zero code is zero
// - Straight binary: zero code, zero volts
// - Span multiplier 2, 4 or 4.32
// - Select 001 takes three low bits
`timescale 1ns/1ns
`include "quad_dac_frame_defines.svh"

module quad_dac_serial_frame_decoder #(
  parameter int DAC_BITS = `DAC_BITS_DEF
) (
  input  wire logic                                core_clk,       // System clock
  input  wire logic                                rst,            // Async reset, high
  input  wire logic                                ce,             // Core clock enable
  input  wire logic                                serialClk,      // Link shift clock
  input  wire logic                                syncN,          // Frame sync, low in frame
  input  wire logic                                serialDataIn,   // Serial data in
  input  wire logic                                twosCompPin,    // 1: bipolar twos complement
  output logic                                     serialDataOut,  // Readback data out
  output quad_dac_frame_pkg::dac_word_t  [3:0]     chanCode,       // Offset or straight code
  output quad_dac_frame_pkg::span_x100_t [3:0]     chanSpanX100,   // Span factor times 100
  output logic                           [3:0]     chanBipolar,    // Range is bipolar
  output logic [`POWER_W-1:0]                      powerCtrl,      // Power control register
  output logic [`CTRL_W-1:0]                       ctrlCfg         // Control option bits
);

  localparam logic [15:0] RES_MASK = 16'(16'hffff << (16 - DAC_BITS));

  // ----------------------------------------------------------------
  // Link domain: shift in frames
  // ----------------------------------------------------------------
  logic                       linkIdle;
  logic [`FRAME_CNT_W-1:0]    bitCnt_r;
  quad_dac_frame_pkg::frame_t shiftReg_r;
  quad_dac_frame_pkg::frame_t frameWord_r;
  logic                       frameTgl_r;

  assign linkIdle = rst | syncN;

  // Sync high clears the count, so a short frame never decodes
  always_ff @(posedge serialClk or posedge linkIdle) begin
    if (linkIdle) begin
      bitCnt_r   <= '0;
      shiftReg_r <= '0;
    end else if (bitCnt_r < `FRAME_BITS) begin
      shiftReg_r <= {shiftReg_r[22:0], serialDataIn};
      bitCnt_r   <= bitCnt_r + 5'h01;
    end
  end

  // Word held stable until the next full frame, read by core after toggle
  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      frameWord_r <= '0;
      frameTgl_r  <= 1'b0;
    end else if (!syncN && bitCnt_r == `FRAME_LAST_BIT) begin
      frameWord_r <= {shiftReg_r[22:0], serialDataIn};
      frameTgl_r  <= ~frameTgl_r;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: readback shift out
  // ----------------------------------------------------------------
  quad_dac_frame_pkg::frame_t rdWord_r;
  logic                       rdTgl_r;
  logic                       rdS1_r;
  logic                       rdS2_r;
  logic                       rdS3_r;
  quad_dac_frame_pkg::frame_t rdWordLink_r;
  quad_dac_frame_pkg::frame_t sdoShift_r;

  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      rdS1_r       <= 1'b0;
      rdS2_r       <= 1'b0;
      rdS3_r       <= 1'b0;
      rdWordLink_r <= '0;
    end else begin
      rdS1_r <= rdTgl_r;
      rdS2_r <= rdS1_r;
      rdS3_r <= rdS2_r;
      if (rdS2_r != rdS3_r) begin
        rdWordLink_r <= rdWord_r;
      end
    end
  end

  always_ff @(posedge serialClk or posedge rst) begin
    if (rst) begin
      sdoShift_r <= '0;
    end else if (!syncN && bitCnt_r == '0) begin
      sdoShift_r <= rdWordLink_r;
    end else if (!syncN) begin
      sdoShift_r <= {sdoShift_r[22:0], 1'b0};
    end
  end

  assign serialDataOut = sdoShift_r[23];

  // ----------------------------------------------------------------
  // Core domain: crossings
  // ----------------------------------------------------------------
  logic ftS1_r;
  logic ftS2_r;
  logic ftS3_r;
  logic twS1_r;
  logic twS2_r;
  logic frameNew;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ftS1_r <= 1'b0;
      ftS2_r <= 1'b0;
      ftS3_r <= 1'b0;
      twS1_r <= 1'b0;
      twS2_r <= 1'b0;
    end else if (ce) begin
      ftS1_r <= frameTgl_r;
      ftS2_r <= ftS1_r;
      ftS3_r <= ftS2_r;
      twS1_r <= twosCompPin;
      twS2_r <= twS1_r;
    end
  end

  assign frameNew = ce & (ftS2_r ^ ftS3_r);

  // ----------------------------------------------------------------
  // Core domain: frame decode
  // ----------------------------------------------------------------
  logic                         isRead;
  logic [2:0]                   regSel;
  logic [2:0]                   chanAddr;
  quad_dac_frame_pkg::dac_word_t dataFld;
  logic [3:0]                   chanHit;
  logic [1:0]                   rdChan;

  assign isRead   = frameWord_r[`FLD_RW];
  assign regSel   = frameWord_r[`FLD_SEL_HI:`FLD_SEL_LO];
  assign chanAddr = frameWord_r[`FLD_ADDR_HI:`FLD_ADDR_LO];
  assign dataFld  = frameWord_r[`FLD_DATA_HI:0];
  assign rdChan   = chanAddr[1:0];

  always_comb begin
    chanHit = 4'h0;
    if (chanAddr == `ADDR_ALL) begin
      chanHit = 4'hf;
    end else if (chanAddr[2] == 1'b0) begin
      chanHit[chanAddr[1:0]] = 1'b1;
    end
  end

  quad_dac_frame_pkg::dac_word_t  [3:0] dacData_r;
  quad_dac_frame_pkg::range_code_t [3:0] range_r;
  logic                           [3:0] wrEn;

  // Undefined address yields no hit, so nothing is written
  assign wrEn = (frameNew && !isRead) ? chanHit : 4'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dacData_r <= {4{`RESET_DATA}};
      range_r   <= {4{`RESET_RANGE}};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wrEn[i] && regSel == `SEL_DAC) begin
          dacData_r[i] <= dataFld & RES_MASK;
        end else if (wrEn[i] && regSel == `SEL_RANGE) begin
          range_r[i] <= dataFld[2:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      powerCtrl <= '0;
      ctrlCfg   <= '0;
    end else if (frameNew && !isRead) begin
      if (regSel == `SEL_POWER && chanAddr <= `ADDR_ALL) begin
        powerCtrl <= dataFld[`POWER_W-1:0];
      end else if (regSel == `SEL_CTRL && chanAddr == `CTRL_ADDR_CFG) begin
        ctrlCfg <= dataFld[`CTRL_W-1:0];
      end
    end
  end

  // Read answer; broadcast address reads channel A
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdWord_r <= '0;
      rdTgl_r  <= 1'b0;
    end else if (frameNew && isRead) begin
      rdTgl_r <= ~rdTgl_r;
      if (regSel == `SEL_DAC) begin
        rdWord_r <= {frameWord_r[23:16], dacData_r[chanAddr[2] ? 2'h0 : rdChan]};
      end else if (regSel == `SEL_RANGE) begin
        rdWord_r <= {frameWord_r[23:16], 13'h0000, range_r[chanAddr[2] ? 2'h0 : rdChan]};
      end else if (regSel == `SEL_POWER) begin
        rdWord_r <= {frameWord_r[23:16], 5'h00, powerCtrl};
      end else if (regSel == `SEL_CTRL) begin
        rdWord_r <= {frameWord_r[23:16], 12'h000, ctrlCfg};
      end else begin
        rdWord_r <= {frameWord_r[23:16], 16'h0000};
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: coding and span per channel
  // ----------------------------------------------------------------
  function automatic quad_dac_frame_pkg::span_x100_t spanOf(input logic [2:0] rc);
    if (rc == `RANGE_U5 || rc == `RANGE_B5) begin
      spanOf = `SPAN_X100_5;
    end else if (rc == `RANGE_U10 || rc == `RANGE_B10) begin
      spanOf = `SPAN_X100_10;
    end else if (rc == `RANGE_U10P8 || rc == `RANGE_B10P8) begin
      spanOf = `SPAN_X100_10P8;
    end else begin
      spanOf = `SPAN_X100_NONE;
    end
  endfunction : spanOf

  // Bipolar output code is always offset binary so the analog side sees one form
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chanCode     <= '0;
      chanSpanX100 <= '0;
      chanBipolar  <= '0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        chanSpanX100[i] <= spanOf(range_r[i]);
        chanBipolar[i]  <= (range_r[i] >= `RANGE_B5) && (range_r[i] <= `RANGE_B10P8);
        if (twS2_r && range_r[i] >= `RANGE_B5) begin
          chanCode[i] <= {~dacData_r[i][15], dacData_r[i][14:0]};
        end else begin
          chanCode[i] <= dacData_r[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_full_frame;
    @(posedge serialClk) disable iff (rst)
    (!syncN && bitCnt_r == `FRAME_LAST_BIT) |=> $changed(frameTgl_r);
  endproperty
  a_full_frame: assert property (p_full_frame) else $error("frame not taken at 24 bits");

  property p_msb_first;
    @(posedge serialClk) disable iff (linkIdle)
    (bitCnt_r < 5'h17) |=> (shiftReg_r[0] == $past(serialDataIn))
      && (shiftReg_r[23:1] == $past(shiftReg_r[22:0]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

  property p_dac_write;
    @(posedge core_clk) disable iff (rst)
    (frameNew && !isRead && regSel == `SEL_DAC && chanAddr == 3'h1)
      |=> (dacData_r[1] == ($past(dataFld) & RES_MASK));
  endproperty
  a_dac_write: assert property (p_dac_write) else $error("data write missed");

  property p_broadcast;
    @(posedge core_clk) disable iff (rst)
    (frameNew && !isRead && regSel == `SEL_DAC && chanAddr == `ADDR_ALL)
      |=> (dacData_r[0] == dacData_r[3]) && (dacData_r[1] == dacData_r[2])
      && (dacData_r[0] == dacData_r[1]);
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast not applied");

  property p_undef_ignored;
    @(posedge core_clk) disable iff (rst)
    (frameNew && (regSel[2] || (chanAddr > 3'h4)))
      |=> $stable(dacData_r) && $stable(range_r) && $stable(powerCtrl) && $stable(ctrlCfg);
  endproperty
  a_undef_ignored: assert property (p_undef_ignored) else $error("undefined frame acted");

  property p_range_write;
    @(posedge core_clk) disable iff (rst)
    (frameNew && !isRead && regSel == `SEL_RANGE && chanAddr == 3'h2)
      |=> (range_r[2] == $past(dataFld[2:0]));
  endproperty
  a_range_write: assert property (p_range_write) else $error("range write missed");

  property p_read_answer;
    @(posedge core_clk) disable iff (rst)
    (frameNew && isRead) |=> (rdTgl_r != $past(rdTgl_r))
      && (rdWord_r[23:16] == $past(frameWord_r[23:16]));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  property p_low_bits;
    @(posedge core_clk) disable iff (rst)
    ((dacData_r[2] & ~RES_MASK) == 16'h0000);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("unused bits stored");

  property p_twos_code;
    @(posedge core_clk) disable iff (rst)
    (ce && twS2_r && range_r[2] == `RANGE_B10P8)
      |=> (chanCode[2] == {~$past(dacData_r[2][15]), $past(dacData_r[2][14:0])});
  endproperty
  a_twos_code: assert property (p_twos_code) else $error("twos coding wrong");

  property p_span;
    @(posedge core_clk) disable iff (rst)
    (ce && range_r[2] == `RANGE_B10P8) |=> (chanSpanX100[2] == `SPAN_X100_10P8) && chanBipolar[2];
  endproperty
  a_span: assert property (p_span) else $error("span wrong");

endmodule : quad_dac_serial_frame_decoder

//--- testbench/host_serial_port.sv
// Host serial port model that shifts command frames into the decoder
`timescale 1ns/1ns

module host_serial_port (
  output logic      serialClk,     // Link clock, also pulsed with sync high between frames
  output logic      syncN,         // Frame sync, low in frame
  output logic      serialDataIn,  // Data to the device
  input  wire logic serialDataOut  // Readback from the device
);
  logic [23:0] rxWord;

  initial begin
    serialClk = 1'b0;
    syncN = 1'b1;
    serialDataIn = 1'b0;
    rxWord = '0;
  end

  task automatic idle_clocks(input int n);
    repeat (n) begin
      #24 serialClk = 1'b1;
      #24 serialClk = 1'b0;
    end
  endtask : idle_clocks

  // Trailing clocks with sync high let the device copy its readback word
  task automatic send_frame(input logic [23:0] word, input int nBits);
    syncN = 1'b0;
    for (int k = 0; k < nBits; k++) begin
      serialDataIn = (k == 1) ? 1'b0 : word[23-k];
      idle_clocks(1);
      rxWord[23-k] = serialDataOut;
    end
    #24 syncN = 1'b1;
    serialDataIn = ~serialDataIn;
    idle_clocks(8);
  endtask : send_frame
endmodule : host_serial_port

//--- testbench/testbench.sv
// Self-checking bench of the serial frame decoder
`timescale 1ns/1ns
`include "quad_dac_frame_defines.svh"

module testbench;
  localparam int          DAC_BITS = 12;
  localparam int          LIMIT    = 20000;
  localparam logic [15:0] MASK     = 16'hffff << (16 - DAC_BITS);
  logic                                 core_clk;
  logic                                 rst;
  logic                                 ce;
  logic                                 twosCompPin;
  logic                                 serialClk;
  logic                                 syncN;
  logic                                 serialDataIn;
  logic                                 serialDataOut;
  quad_dac_frame_pkg::dac_word_t  [3:0] chanCode;
  quad_dac_frame_pkg::span_x100_t [3:0] chanSpanX100;
  logic [3:0]                           chanBipolar;
  logic [`POWER_W-1:0]                  powerCtrl;
  logic [`CTRL_W-1:0]                   ctrlCfg;
  logic [15:0]                          expCode [4];
  int                                   errors;
  int                                   n_compared;
  int                                   cycles;

  quad_dac_serial_frame_decoder #(.DAC_BITS(DAC_BITS)) dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .serialClk(serialClk), .syncN(syncN),
    .serialDataIn(serialDataIn), .twosCompPin(twosCompPin), .serialDataOut(serialDataOut),
    .chanCode(chanCode), .chanSpanX100(chanSpanX100), .chanBipolar(chanBipolar),
    .powerCtrl(powerCtrl), .ctrlCfg(ctrlCfg));

  host_serial_port host (.serialClk(serialClk), .syncN(syncN), .serialDataIn(serialDataIn),
                         .serialDataOut(serialDataOut));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : check

  function automatic logic [23:0] frm(input logic rd, input logic [2:0] sel,
                                      input logic [2:0] adr, input logic [15:0] data);
    return {rd, 1'b0, sel, adr, data};
  endfunction : frm

  // Margin covers sync, decode and the output register stage
  task automatic put(input logic [23:0] f);
    host.send_frame(f, 24);
    repeat (12) @(posedge core_clk);
  endtask : put

  task automatic check_codes;
    for (int i = 0; i < 4; i++) check("chanCode", chanCode[i], expCode[i] & MASK);
  endtask : check_codes

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check_codes();
    check("chanSpanX100", chanSpanX100[3], `SPAN_X100_5);
    check("powerCtrl", powerCtrl, 32'h0);
    check("ctrlCfg", ctrlCfg, 32'h0);
    $display("done reset values");
  endtask : t_reset

  task automatic t_channels;
    for (int i = 0; i < 4; i++) begin
      expCode[i] = 16'(16'h135f + 16'h2222 * i);
      put(frm(1'b0, `SEL_DAC, 3'(i), expCode[i]));
      check_codes();
    end
    expCode = '{4{16'hfff7}};
    put(frm(1'b0, `SEL_DAC, `ADDR_ALL, 16'hfff7));
    check_codes();
    $display("done channel data");
  endtask : t_channels

  task automatic t_ranges;
    logic [8:0] span [3] = '{`SPAN_X100_5, `SPAN_X100_10, `SPAN_X100_10P8};
    for (int c = 0; c < 6; c++) begin
      put(frm(1'b0, `SEL_RANGE, 3'h2, {13'h1fff, 3'(c)}));
      check("chanSpanX100", chanSpanX100[2], span[c % 3]);
      check("chanBipolar", chanBipolar, {1'b0, c >= 3, 2'b00});
      check("chanSpanX100", chanSpanX100[1], `SPAN_X100_5);
    end
    $display("done ranges");
  endtask : t_ranges

  task automatic t_coding;
    @(posedge core_clk) twosCompPin <= 1'b1;
    put(frm(1'b0, `SEL_DAC, 3'h2, 16'h7ff5));
    check("chanCode", chanCode[2], 16'hfff0);
    check("chanCode", chanCode[0], expCode[0] & MASK);
    put(frm(1'b0, `SEL_DAC, 3'h2, 16'h0003));
    check("chanCode", chanCode[2], 16'h8000);
    // Enable low must freeze the coding pin sync and the outputs
    @(posedge core_clk) ce <= 1'b0;
    twosCompPin <= 1'b0;
    repeat (6) @(posedge core_clk);
    check("chanCode", chanCode[2], 16'h8000);
    ce <= 1'b1;
    repeat (6) @(posedge core_clk);
    check("chanCode", chanCode[2], 16'h0000);
    expCode[2] = 16'h8000;
    put(frm(1'b0, `SEL_DAC, 3'h2, 16'h8000));
    check_codes();
    $display("done coding");
  endtask : t_coding

  task automatic t_refused;
    host.send_frame(frm(1'b0, `SEL_DAC, 3'h0, 16'h1230), 20);
    repeat (12) @(posedge core_clk);
    put(frm(1'b0, 3'h4, 3'h0, 16'h1230));
    put(frm(1'b0, 3'h7, 3'h1, 16'h1230));
    put(frm(1'b0, `SEL_DAC, 3'h5, 16'h1230));
    put(frm(1'b0, `SEL_RANGE, 3'h7, 16'h0004));
    put(frm(1'b0, `SEL_POWER, 3'h6, 16'h0111));
    check("powerCtrl", powerCtrl, 32'h0);
    check_codes();
    check("chanBipolar", chanBipolar, 32'h4);
    $display("done refused frames");
  endtask : t_refused

  task automatic t_regs;
    logic [2:0]  sel [5] = '{`SEL_DAC, `SEL_RANGE, `SEL_RANGE, `SEL_POWER, `SEL_CTRL};
    logic [2:0]  adr [5] = '{3'h1, 3'h2, `ADDR_ALL, 3'h0, `CTRL_ADDR_CFG};
    logic [15:0] val [5];
    logic [23:0] f;
    put(frm(1'b0, `SEL_POWER, 3'h0, 16'hf5a5));
    check("powerCtrl", powerCtrl, 32'h5a5);
    put(frm(1'b0, `SEL_CTRL, `CTRL_ADDR_CFG, 16'hfffa));
    check("ctrlCfg", ctrlCfg, 32'ha);
    val = '{expCode[1] & MASK, 16'h0005, 16'h0000, 16'h05a5, 16'h000a};
    for (int k = 0; k < 5; k++) begin
      f = frm(1'b1, sel[k], adr[k], 16'h0000);
      put(f);
      put(frm(1'b0, `SEL_CTRL, 3'h0, 16'h0000));
      check("readback", host.rxWord, {f[23:16], val[k]});
    end
    check_codes();
    $display("done register access");
  endtask : t_regs

  // ---------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      $display("unexpected timeout after %0d cycles", cycles);
      tally_and_finish();
    end
  end

  initial begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    expCode = '{4{16'h0000}};
    rst = 1'b1;
    ce = 1'b1;
    twosCompPin = 1'b0;
    host.idle_clocks(2);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_channels();
    t_ranges();
    t_coding();
    t_refused();
    t_regs();
    tally_and_finish();
  end
endmodule : testbench
